/* File: src/preset_counter_pkg.sv */
package preset_counter_pkg;

    // Value widths: six-digit counts fit in 20 bits, signed totals in 21.
    localparam int VAL_W = 20;
    localparam int SVAL_W = 21;
    localparam logic [19:0] FULL_SCALE = 20'hf423f;
    localparam logic [20:0] TOTAL_MIN = 21'h1e7961;
    localparam logic [13:0] ALARM_MAX = 14'h270f;
    localparam logic [9:0] THOUSAND = 10'h3e8;
    localparam logic [19:0] BATCH_LIMIT_MAX = 20'hf423f;

    // Clock and one-shot time base: 10 ms ticks from a 100 MHz clock.
    localparam int CLK_HZ = 100000000;
    localparam int TICK_MS = 10;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam logic [13:0] ONESHOT_MIN = 14'h0001;
    localparam logic [13:0] ONESHOT_MAX = 14'h270f;

    // Minimum count signal width in microseconds for each speed.
    localparam int SLOW_WIDTH_US = 16700;
    localparam int FAST_WIDTH_US = 100;
    localparam int SLOW_WIDTH_CYC = SLOW_WIDTH_US * (CLK_HZ / 1000000);
    localparam int FAST_WIDTH_CYC = FAST_WIDTH_US * (CLK_HZ / 1000000);

    // Counter configuration.
    typedef enum logic [2:0] {
        CFG_ONE_STAGE = 3'h0,
        CFG_TWO_STAGE = 3'h1,
        CFG_TOTAL = 3'h2,
        CFG_BATCH = 3'h3,
        CFG_DUAL = 3'h4,
        CFG_TWIN = 3'h5
    } config_e;

    // Output behaviour once the count completes.
    typedef enum logic [1:0] {
        OUT_HOLD = 2'h0,
        OUT_ONESHOT = 2'h1,
        OUT_INSTANT = 2'h2
    } out_mode_e;

endpackage

/* File: src/count_pulse_if.sv */
`timescale 1ns/1ps
interface count_pulse_if;
    logic pulse;
    logic level;
    modport src (output pulse, output level);
    modport dst (input pulse, input level);
endinterface

/* File: src/input_filter.sv */
`timescale 1ns/1ps
module input_filter
    import preset_counter_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic pin_i,
    input wire logic slow_i,
    count_pulse_if.src out
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic lvl;
        logic [20:0] cnt;
        logic pulse;
    } filt_s;

    filt_s st_reg;
    filt_s st_next;
    logic [20:0] width;

    // Accept a level only after it has been stable for half the signal width.
    always_comb begin
        st_next = st_reg;
        width = slow_i ? 21'(SLOW_WIDTH_CYC / 2) : 21'(FAST_WIDTH_CYC / 2);
        st_next.s1 = pin_i;
        st_next.s2 = st_reg.s1;
        st_next.pulse = 1'b0;
        if (st_reg.s2 == st_reg.lvl) begin
            st_next.cnt = '0;
        end else if (st_reg.cnt >= width) begin
            st_next.lvl = st_reg.s2;
            st_next.cnt = '0;
            st_next.pulse = st_reg.s2;
        end else begin
            st_next.cnt = st_reg.cnt + 21'h1;
        end
    end

    // State register.
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign out.pulse = st_reg.pulse;
    assign out.level = st_reg.lvl;
endmodule

/* File: src/on_count_meter.sv */
`timescale 1ns/1ps
module on_count_meter
    import preset_counter_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic out_i,
    input wire logic [13:0] alarm_i,
    output logic [13:0] monitor_o,
    output logic alarm_o
);
    typedef struct packed {
        logic prev;
        logic [9:0] sub;
        logic [13:0] thou;
        logic alarm;
    } meter_s;

    meter_s st_reg;
    meter_s st_next;

    // Count rising edges of the output in thousands and compare.
    always_comb begin
        st_next = st_reg;
        st_next.prev = out_i;
        if (out_i && !st_reg.prev) begin
            if (st_reg.sub == THOUSAND - 10'h1) begin
                st_next.sub = '0;
                if (st_reg.thou != ALARM_MAX) begin
                    st_next.thou = st_reg.thou + 14'h1;
                end
            end else begin
                st_next.sub = st_reg.sub + 10'h1;
            end
        end
        st_next.alarm = (alarm_i != 14'h0)
            && (st_reg.thou >= alarm_i) && (st_reg.sub != 10'h0
            || st_reg.thou > alarm_i);
    end

    // State register.
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign monitor_o = st_reg.thou;
    assign alarm_o = st_reg.alarm;
endmodule

/* File: src/multimode_preset_counter.sv */
`timescale 1ns/1ps
// What this block does
// - Batch limit setting accepted from 1 to 999999.
// - Output allocation swaps which stage drives transistor and relay.
// - ON-count alarm threshold in thousands, zero disables it.
// - Alarm raised when an ON count exceeds its threshold.
// - Monitors show ON counts divided by one thousand, read-only.
// - Preset modes drive outputs per mode on reaching set values.
// - Forecast setting holds stage-one value as deviation from set value.
// - Batch count steps per completion; batch output on at batch value.
// - Dual value is first plus or minus second input count.
// - Dual mode drives outputs when dual value reaches its set value.
// - Both dual inputs count up only like the first input.
// - Count pulses shorter than half the minimum width are filtered out.
// - Single-stage, total and dual modes switch both outputs together.
// - Present count wraps to zero after 999999.
// - Primary reset inhibits first-input counting and ends an active one-shot.
// - After power return, held outputs and one-shots restart.
// - One-shot duration programmable 0.01 s to 99.99 s.
// - Total keeps its count through present resets; total reset clears it.
// - Total counts up from 0 to 999999 and wraps to zero at full scale.
// - Batch output latches until batch reset, which clears and holds.
// - Batch value zero counts without output; batch count wraps.
// - Lowering batch value below count turns batch output on.
// - Forecast output on at forecast point, or at start if too large.
module multimode_preset_counter
    import preset_counter_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic first_count_input_i,
    input wire logic second_count_input_i,
    input wire logic first_reset_i,
    input wire logic second_reset_i,
    input wire logic front_reset_i,
    input wire logic total_shown_i,
    input wire logic slow_speed_i,
    input wire preset_counter_pkg::config_e config_i,
    input wire preset_counter_pkg::out_mode_e out_mode_i,
    input wire logic forecast_i,
    input wire logic subtract_i,
    input wire logic allocation_swap_i,
    input wire logic [19:0] first_set_value_i,
    input wire logic [19:0] second_set_value_i,
    input wire logic [20:0] dual_set_value_i,
    input wire logic [19:0] batch_set_value_i,
    input wire logic [19:0] batch_limit_setting_i,
    input wire logic [13:0] oneshot_time_i,
    input wire logic [13:0] alarm_shared_i,
    input wire logic [13:0] alarm_first_i,
    input wire logic [13:0] alarm_second_i,
    input wire logic restore_valid_i,
    input wire logic restore_first_i,
    input wire logic restore_second_i,
    input wire logic restore_batch_i,
    output logic first_control_output_o,
    output logic second_control_output_o,
    output logic batch_output_o,
    output logic [19:0] present_count_o,
    output logic [19:0] second_count_o,
    output logic [20:0] dual_value_o,
    output logic [20:0] total_count_o,
    output logic [19:0] batch_count_o,
    output logic [13:0] on_count_monitor_o,
    output logic [13:0] on_count_monitor_first_o,
    output logic [13:0] on_count_monitor_second_o,
    output logic on_count_alarm_o
);
    typedef struct packed {
        logic [2:0] rs1;
        logic [2:0] rs2;
        logic [2:0] rsf;
        logic [19:0] pv1;
        logic [19:0] pv2;
        logic [20:0] total;
        logic [19:0] batch;
        logic batch_out;
        logic st1;
        logic st2;
        logic [13:0] os1;
        logic [13:0] os2;
        logic [19:0] tick_cnt;
        logic restored;
        logic done1;
        logic done2;
    } ctr_s;

    ctr_s st_reg;
    ctr_s st_next;
    logic out_a_reg;
    logic out_b_reg;
    logic [20:0] dual_reg;
    logic [13:0] mon_s;
    logic [13:0] mon_a;
    logic [13:0] mon_b;
    logic alm_s;
    logic alm_a;
    logic alm_b;
    logic [13:0] os_len;
    logic [19:0] batch_sv;
    logic [19:0] stage1_target;
    logic tick;
    logic rst1;
    logic rst2;
    logic rstf;
    logic reach1;
    logic reach2;
    logic hit1;
    logic hit2;
    logic one_output;
    logic [20:0] dual_val;
    logic dual_reach;

    count_pulse_if cp1_if ();
    count_pulse_if cp2_if ();

    // Count inputs are synchronised and width-filtered.
    input_filter u_filt1 (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .pin_i(first_count_input_i),
        .slow_i(slow_speed_i),
        .out(cp1_if.src)
    );

    input_filter u_filt2 (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .pin_i(second_count_input_i),
        .slow_i(slow_speed_i),
        .out(cp2_if.src)
    );

    // Step a count by one with a wrap at full scale.
    function automatic logic [19:0] step_wrap(input logic [19:0] v);
        step_wrap = (v >= FULL_SCALE) ? 20'h0 : v + 20'h1;
    endfunction

    // Clamp a setting into the range 1..max (the one-shot and batch limit).
    function automatic logic [19:0] clamp1(input logic [19:0] v,
                                           input logic [19:0] mx);
        clamp1 = (v == 20'h0) ? 20'h1 : ((v > mx) ? mx : v);
    endfunction

    // Derived setting values.
    always_comb begin
        os_len = 14'(clamp1({6'h0, oneshot_time_i},
                            {6'h0, ONESHOT_MAX}));
        batch_sv = (batch_set_value_i >
                    clamp1(batch_limit_setting_i, BATCH_LIMIT_MAX)) ?
                   clamp1(batch_limit_setting_i, BATCH_LIMIT_MAX) :
                   batch_set_value_i;
        // Forecast point is the deviation below the second set value.
        if (forecast_i) begin
            stage1_target = (first_set_value_i >= second_set_value_i) ?
                20'h0 : second_set_value_i - first_set_value_i;
        end else begin
            stage1_target = first_set_value_i;
        end
        tick = (st_reg.tick_cnt == 20'(TICK_CYCLES - 1));
        rst1 = st_reg.rs1[2];
        rst2 = st_reg.rs2[2];
        rstf = st_reg.rsf[2];
        one_output = (config_i == CFG_ONE_STAGE) || (config_i == CFG_TOTAL)
            || (config_i == CFG_DUAL) || (config_i == CFG_BATCH);
        if (subtract_i) begin
            dual_val = {1'b0, st_reg.pv1} - {1'b0, st_reg.pv2};
        end else begin
            dual_val = {1'b0, st_reg.pv1} + {1'b0, st_reg.pv2};
        end
        dual_reach = (dual_val == dual_set_value_i);
        reach2 = (config_i == CFG_DUAL) ? dual_reach :
                 (st_reg.pv1 >= second_set_value_i);
        if (config_i == CFG_TWIN) begin
            reach1 = st_reg.pv2 >= second_set_value_i;
            reach2 = st_reg.pv1 >= first_set_value_i;
        end else if (config_i == CFG_TWO_STAGE) begin
            reach1 = st_reg.pv1 >= stage1_target;
        end else begin
            reach1 = reach2;
        end
        hit1 = reach1 && !st_reg.done1;
        hit2 = reach2 && !st_reg.done2;
    end

    // Counting, reset handling, one-shots and batch logic.
    always_comb begin
        st_next = st_reg;
        st_next.rs1 = {st_reg.rs1[1:0], first_reset_i};
        st_next.rs2 = {st_reg.rs2[1:0], second_reset_i};
        st_next.rsf = {st_reg.rsf[1:0], front_reset_i};
        st_next.tick_cnt = tick ? 20'h0 : st_reg.tick_cnt + 20'h1;
        // First input counts unless its reset or the front reset is held.
        if (cp1_if.pulse && !rst1 && !rstf) begin
            st_next.pv1 = step_wrap(st_reg.pv1);
            if (st_reg.total == {1'b0, FULL_SCALE}) begin
                st_next.total = '0;
            end else begin
                st_next.total = st_reg.total + 21'h1;
            end
        end
        // Second input counts up only in dual and twin use.
        if (cp2_if.pulse && !rst2 && !rstf && (config_i == CFG_DUAL
            || config_i == CFG_TWIN)) begin
            st_next.pv2 = step_wrap(st_reg.pv2);
        end
        st_next.done1 = reach1;
        st_next.done2 = reach2;
        // Stage outputs follow the selected output mode.
        case (out_mode_i)
            OUT_HOLD: begin
                if (hit1) begin
                    st_next.st1 = 1'b1;
                end
                if (hit2) begin
                    st_next.st2 = 1'b1;
                end
            end
            OUT_ONESHOT: begin
                if (hit1) begin
                    st_next.os1 = os_len;
                end else if (tick && st_reg.os1 != 14'h0) begin
                    st_next.os1 = st_reg.os1 - 14'h1;
                end
                if (hit2) begin
                    st_next.os2 = os_len;
                end else if (tick && st_reg.os2 != 14'h0) begin
                    st_next.os2 = st_reg.os2 - 14'h1;
                end
                st_next.st1 = st_next.os1 != 14'h0;
                st_next.st2 = st_next.os2 != 14'h0;
            end
            OUT_INSTANT: begin
                st_next.st1 = reach1;
                st_next.st2 = reach2;
            end
            default: begin
                st_next.st1 = 1'b0;
                st_next.st2 = 1'b0;
            end
        endcase
        // Batch count steps on each completion of the main count.
        if (config_i == CFG_BATCH && hit2) begin
            st_next.batch = step_wrap(st_reg.batch);
        end
        if (batch_sv != 20'h0 && st_next.batch >= batch_sv) begin
            st_next.batch_out = 1'b1;
        end
        // Primary reset clears the present count and ends one-shots.
        if (rst1 || rstf) begin
            st_next.pv1 = '0;
            st_next.st1 = 1'b0;
            st_next.st2 = 1'b0;
            st_next.os1 = '0;
            st_next.os2 = '0;
            st_next.done1 = 1'b0;
            st_next.done2 = 1'b0;
        end
        // Second reset clears total, batch and second count in every mode.
        if (rst2 || (rstf && total_shown_i)) begin
            st_next.total = '0;
            st_next.batch = '0;
            st_next.batch_out = 1'b0;
            st_next.pv2 = '0;
        end
        // Restore saved output states once after power returns.
        if (!st_reg.restored && restore_valid_i) begin
            st_next.restored = 1'b1;
            st_next.st1 = restore_first_i;
            st_next.st2 = restore_second_i;
            st_next.batch_out = restore_batch_i;
            st_next.os1 = restore_first_i ? os_len : 14'h0;
            st_next.os2 = restore_second_i ? os_len : 14'h0;
            st_next.done1 = restore_first_i;
            st_next.done2 = restore_second_i;
        end
    end

    // State and output registers.
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_reg <= '0;
            out_a_reg <= 1'b0;
            out_b_reg <= 1'b0;
            dual_reg <= '0;
        end else begin
            st_reg <= st_next;
            dual_reg <= dual_val;
            // Batch mode gives the first output to the batch latch.
            if (one_output && config_i != CFG_BATCH) begin
                out_a_reg <= st_next.st2;
                out_b_reg <= st_next.st2;
            end else if (config_i == CFG_BATCH) begin
                out_a_reg <= st_next.batch_out;
                out_b_reg <= st_next.st2;
            end else if (allocation_swap_i) begin
                out_a_reg <= st_next.st2;
                out_b_reg <= st_next.st1;
            end else begin
                out_a_reg <= st_next.st1;
                out_b_reg <= st_next.st2;
            end
        end
    end

    // ON-count meters for the shared output and each output.
    on_count_meter u_meter_s (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .out_i(out_a_reg | out_b_reg),
        .alarm_i(alarm_shared_i),
        .monitor_o(mon_s),
        .alarm_o(alm_s)
    );

    on_count_meter u_meter_a (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .out_i(out_a_reg),
        .alarm_i(alarm_first_i),
        .monitor_o(mon_a),
        .alarm_o(alm_a)
    );

    on_count_meter u_meter_b (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .out_i(out_b_reg),
        .alarm_i(alarm_second_i),
        .monitor_o(mon_b),
        .alarm_o(alm_b)
    );

    // Register-fed outputs.
    assign first_control_output_o = out_a_reg;
    assign second_control_output_o = out_b_reg;
    assign batch_output_o = st_reg.batch_out;
    assign present_count_o = st_reg.pv1;
    assign second_count_o = st_reg.pv2;
    assign dual_value_o = dual_reg;
    assign total_count_o = st_reg.total;
    assign batch_count_o = st_reg.batch;
    assign on_count_monitor_o = mon_s;
    assign on_count_monitor_first_o = mon_a;
    assign on_count_monitor_second_o = mon_b;
    assign on_count_alarm_o = alm_s | alm_a | alm_b;
endmodule

/* File: tb/preset_counter_monitor.sv */
`timescale 1ns/1ps
// Watches the counter ports and flags any broken relation.
module preset_counter_monitor
    import preset_counter_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic first_reset_i,
    input wire logic second_reset_i,
    input wire preset_counter_pkg::config_e config_i,
    input wire logic subtract_i,
    input wire logic allocation_swap_i,
    input wire logic [13:0] alarm_shared_i,
    input wire logic [13:0] alarm_first_i,
    input wire logic [13:0] alarm_second_i,
    input wire logic first_control_output_o,
    input wire logic second_control_output_o,
    input wire logic batch_output_o,
    input wire logic [19:0] present_count_o,
    input wire logic [19:0] second_count_o,
    input wire logic [20:0] dual_value_o,
    input wire logic [19:0] batch_count_o,
    input wire logic [13:0] on_count_monitor_o,
    input wire logic on_count_alarm_o
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    // A held batch reset leaves the batch count at zero and output off.
    AST_BATCH_CLEAR: assert property (
        (config_i == CFG_BATCH && second_reset_i)[*6]
        |=> batch_count_o == 20'h0 && !batch_output_o)
        else $error("batch reset did not clear");
    // A held primary reset clears the count and the output.
    AST_RESET_CLEARS: assert property (
        (first_reset_i && config_i == CFG_ONE_STAGE)[*5]
        |=> present_count_o == 20'h0 && !first_control_output_o)
        else $error("primary reset did not clear");
    // The present count does not move while the primary reset stays high.
    AST_INHIBIT: assert property (
        first_reset_i[*6] |-> $stable(present_count_o))
        else $error("count moved during reset");
    // The thousands monitor only ever steps up by one.
    AST_MON_STEP: assert property (
        on_count_monitor_o != $past(on_count_monitor_o)
        |-> on_count_monitor_o == $past(on_count_monitor_o) + 14'h1)
        else $error("monitor jumped");
    // Zero thresholds keep the alarm quiet.
    AST_ALARM_OFF: assert property (
        (alarm_shared_i == 14'h0 && alarm_first_i == 14'h0
        && alarm_second_i == 14'h0)[*3] |-> !on_count_alarm_o)
        else $error("alarm while disabled");
    AST_WRAP: assert property (present_count_o <= FULL_SCALE)
        else $error("present count above full scale");
    AST_BATCH_WRAP: assert property (batch_count_o <= FULL_SCALE)
        else $error("batch count above full scale");
    // Flipping the allocation exchanges the two stage outputs.
    AST_SWAP: assert property (
        (config_i == CFG_TWO_STAGE && !first_reset_i
        && $changed(allocation_swap_i)) ##1 ($stable(present_count_o)
        && $stable(allocation_swap_i))[*3]
        |-> first_control_output_o == $past(second_control_output_o, 4)
        && second_control_output_o == $past(first_control_output_o, 4))
        else $error("allocation swap wrong");
    // The dual value follows the two counts by sum or difference.
    AST_DUAL_VALUE: assert property (
        (config_i == CFG_DUAL && $stable(subtract_i)
        && $stable(present_count_o) && $stable(second_count_o))[*3]
        |-> dual_value_o == (subtract_i
        ? {1'b0, present_count_o} - {1'b0, second_count_o}
        : {1'b0, present_count_o} + {1'b0, second_count_o}))
        else $error("dual value wrong");
    // Single-stage, total and dual modes switch both outputs together.
    AST_TOGETHER: assert property (
        (config_i == CFG_ONE_STAGE || config_i == CFG_TOTAL
        || config_i == CFG_DUAL)[*8]
        |-> first_control_output_o == second_control_output_o)
        else $error("outputs differ");
endmodule

bind multimode_preset_counter preset_counter_monitor i_mon (.*);

/* File: tb/count_sensor_model.sv */
`timescale 1ns/1ps
// A clean sensor on both count pins; pins rest low between pulses.
module count_sensor_model (
    input wire logic core_clk_i,
    output logic first_pin_o,
    output logic second_pin_o
);
    localparam int HALF = 5020;

    // Pins start idle.
    initial begin
        first_pin_o = 1'b0;
        second_pin_o = 1'b0;
    end

    // One pulse; both phases outlast the filter's fast-speed half width.
    task automatic send(input logic both);
        @(posedge core_clk_i);
        first_pin_o <= 1'b1;
        second_pin_o <= both;
        repeat (HALF) @(posedge core_clk_i);
        first_pin_o <= 1'b0;
        second_pin_o <= 1'b0;
        repeat (HALF) @(posedge core_clk_i);
    endtask
endmodule

/* File: tb/multimode_preset_counter_tb.sv */
`timescale 1ns/1ps
module multimode_preset_counter_tb;
    import preset_counter_pkg::*;
    typedef struct {
        config_e cfg;
        logic sub;
        logic both;
        logic [19:0] sv;
        logic [19:0] pv;
        logic [20:0] dv;
        logic o1;
        logic o2;
    } row_s;
    logic core_clk_i, rst_n_i, first_count_input_i, second_count_input_i;
    logic first_reset_i, second_reset_i, front_reset_i, total_shown_i;
    logic slow_speed_i, forecast_i, subtract_i, allocation_swap_i;
    config_e config_i;
    out_mode_e out_mode_i;
    logic [19:0] first_set_value_i, second_set_value_i, batch_set_value_i;
    logic [19:0] batch_limit_setting_i, present_count_o, second_count_o;
    logic [19:0] batch_count_o;
    logic [20:0] dual_set_value_i, dual_value_o, total_count_o;
    logic [13:0] oneshot_time_i, alarm_shared_i, alarm_first_i;
    logic [13:0] alarm_second_i, on_count_monitor_o;
    logic [13:0] on_count_monitor_first_o, on_count_monitor_second_o;
    logic restore_valid_i, restore_first_i, restore_second_i;
    logic restore_batch_i, first_control_output_o, second_control_output_o;
    logic batch_output_o, on_count_alarm_o;
    int n_errors = 0;
    int n_checks = 0;
    row_s rows [4];

    multimode_preset_counter i_dut (.*);
    count_sensor_model i_sensor (
        .core_clk_i(core_clk_i),
        .first_pin_o(first_count_input_i),
        .second_pin_o(second_count_input_i)
    );

    // Free-running 100 MHz clock.
    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end

    // Compares one observed value with its expectation.
    task automatic check(input string what, input logic [20:0] seen,
                         input logic [20:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask

    // Loads a mode and clears both counters through the reset inputs.
    task automatic setup(input config_e c, input out_mode_e m,
                         input logic [19:0] sv);
        {first_reset_i, second_reset_i} <= 2'h3;
        config_i <= c;
        out_mode_i <= m;
        first_set_value_i <= sv;
        tick(6);
        {first_reset_i, second_reset_i} <= 2'h0;
        tick(6);
    endtask

    // Prints the counts and the verdict, then stops the run.
    task automatic tally_and_finish();
        $display("Checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Main sequence: power-up restore, table rows, then the awkward cases.
    initial begin
        rows[0] = '{CFG_ONE_STAGE, 0, 0, 20'h1, 20'h1, 21'h0, 1, 1};
        rows[1] = '{CFG_TWO_STAGE, 0, 0, 20'h5, 20'h1, 21'h0, 0, 1};
        rows[2] = '{CFG_DUAL, 0, 1, 20'h0, 20'h1, 21'h2, 1, 1};
        rows[3] = '{CFG_DUAL, 1, 1, 20'h0, 20'h1, 21'h0, 0, 0};
        rst_n_i = 1'b0;
        {first_reset_i, second_reset_i, front_reset_i, total_shown_i} = 4'h0;
        {slow_speed_i, forecast_i, subtract_i, allocation_swap_i} = 4'h0;
        config_i = CFG_ONE_STAGE;
        out_mode_i = OUT_HOLD;
        first_set_value_i = 20'h5;
        second_set_value_i = 20'h1;
        dual_set_value_i = 21'h2;
        batch_set_value_i = 20'h5;
        batch_limit_setting_i = 20'hf423f;
        oneshot_time_i = 14'h1;
        {alarm_shared_i, alarm_first_i, alarm_second_i} = 42'h0;
        {restore_valid_i, restore_first_i, restore_second_i} = 3'h7;
        restore_batch_i = 1'b0;
        tick(5);
        rst_n_i <= 1'b1;
        tick(10);
        check("restored1", first_control_output_o, 1'b1);
        check("restored2", second_control_output_o, 1'b1);
        {restore_valid_i, restore_first_i, restore_second_i} <= 3'h0;
        foreach (rows[i]) begin
            subtract_i <= rows[i].sub;
            setup(rows[i].cfg, OUT_HOLD, rows[i].sv);
            i_sensor.send(rows[i].both);
            tick(4);
            check("present", present_count_o, rows[i].pv);
            check("first_control_output", first_control_output_o, rows[i].o1);
            check("second_control_output", second_control_output_o, rows[i].o2);
            if (rows[i].cfg == CFG_DUAL) begin
                check("dual", dual_value_o, rows[i].dv);
            end
        end
        // A pulse under a held reset is lost; reset cuts a one-shot short.
        setup(CFG_ONE_STAGE, OUT_ONESHOT, 20'h1);
        first_reset_i <= 1'b1;
        i_sensor.send(1'b0);
        check("inhibited", present_count_o, 20'h0);
        first_reset_i <= 1'b0;
        tick(6);
        i_sensor.send(1'b0);
        check("shot_on", first_control_output_o, 1'b1);
        first_reset_i <= 1'b1;
        tick(6);
        check("shot_cut", first_control_output_o, 1'b0);
        // The total survives a present reset but not a front reset.
        setup(CFG_TOTAL, OUT_HOLD, 20'h5);
        i_sensor.send(1'b0);
        first_reset_i <= 1'b1;
        tick(6);
        first_reset_i <= 1'b0;
        check("total_kept", total_count_o, 21'h1);
        check("present_cleared", present_count_o, 20'h0);
        {front_reset_i, total_shown_i} <= 2'h3;
        tick(6);
        {front_reset_i, total_shown_i} <= 2'h0;
        check("total_cleared", total_count_o, 21'h0);
        // Batch output latches on a lowered set value until batch reset.
        setup(CFG_BATCH, OUT_HOLD, 20'h1);
        {alarm_first_i, alarm_second_i} <= {14'h1, 14'h1};
        i_sensor.send(1'b0);
        tick(4);
        check("batch_count", batch_count_o, 20'h1);
        check("batch_idle", batch_output_o, 1'b0);
        check("alarm", on_count_alarm_o, 1'b0);
        check("monitor", on_count_monitor_first_o, 14'h0);
        batch_set_value_i <= 20'h1;
        tick(4);
        check("batch_on", batch_output_o, 1'b1);
        batch_set_value_i <= 20'h5;
        tick(4);
        check("batch_held", batch_output_o, 1'b1);
        second_reset_i <= 1'b1;
        tick(8);
        check("batch_cleared", batch_count_o, 20'h0);
        check("batch_off", batch_output_o, 1'b0);
        // An oversized forecast deviation fires stage one at once.
        forecast_i <= 1'b1;
        second_set_value_i <= 20'h2;
        setup(CFG_TWO_STAGE, OUT_HOLD, 20'h5);
        check("forecast1", first_control_output_o, 1'b1);
        check("forecast2", second_control_output_o, 1'b0);
        allocation_swap_i <= 1'b1;
        tick(4);
        check("swapped1", first_control_output_o, 1'b0);
        check("swapped2", second_control_output_o, 1'b1);
        tally_and_finish();
    end
endmodule
